// *** design/vds_descr.sv ***
// Purpose: self-synchronous descrambler, one octet per step
// Assumes: msb of the octet is the first bit on the line
// Notes:   state holds the last LEN received bits
`timescale 1ns/1ns
`include "vds_map.svh"
module vds_descr #(
	parameter int LEN = `VDS_SCR_LEN
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       en,
	input  wire logic [7:0] din,
	output logic      [7:0] dout
);

	logic [LEN-1:0] sr_q;
	logic [LEN-1:0] sr_d;

	// ==========================================================
	// out = in xor in delayed LEN bits
	always_comb begin
		sr_d = sr_q;
		dout = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			dout[i] = din[i] ^ sr_d[LEN-1]; // see [RULE6]
			sr_d    = {sr_d[LEN-2:0], din[i]};
		end
	end

	// frozen outside payload so both ends stay in step
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sr_q <= '0;
		end else if (en) begin
			sr_q <= sr_d; // see [RULE7]
		end
	end

	// ==========================================================
	// checks
	a_descr_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE7]
		!en |=> $stable(sr_q))
		else $error("descrambler moved outside payload");

endmodule : vds_descr

// *** design/vds_hcs_crc.sv ***
// Purpose: header check octet over three header octets
// Assumes: msb first, zero preset
// Notes:   purely combinational
`timescale 1ns/1ns
`include "vds_map.svh"
module vds_hcs_crc #(
	parameter logic [7:0] POLY = `VDS_HCS_POLY
) (
	input  wire logic [23:0] hdr,
	output logic      [7:0]  crc
);

	// ==========================================================
	// bit serial division, unrolled by the loop
	always_comb begin
		crc = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			if (crc[7] ^ hdr[i]) begin
				crc = {crc[6:0], 1'b0} ^ POLY;
			end else begin
				crc = {crc[6:0], 1'b0};
			end
		end
	end

endmodule : vds_hcs_crc

// *** design/vds_map.svh ***
// Purpose: constants of the container-to-slot sink
// Assumes: 4-bit byte address on the register bus
// Notes:   register offsets, control fields, framing figures
`ifndef VDS_MAP_SVH
`define VDS_MAP_SVH

// ==========================================================
// register map
`define VDS_REG_CTRL   4'h0
`define VDS_REG_STAT   4'h4
`define VDS_REG_LABEL  4'h8

// ==========================================================
// control fields and reset value
`define VDS_CTRL_ACT   0
`define VDS_CTRL_H4    1
`define VDS_CTRL_FDN   2
`define VDS_CTRL_HOB   3
`define VDS_CTRL_RST   4'h0

// ==========================================================
// framing figures
`define VDS_SLOT_LEN   6'h35
`define VDS_SLOT_LAST  6'h34
`define VDS_H4_STEP    6'h2d
`define VDS_HDR_END    6'h03
`define VDS_PAY_FIRST  6'h05
`define VDS_HCS_MASK   8'h55
`define VDS_C2_EXP     8'h14
`define VDS_ALL_ONES   8'hff
`define VDS_HCS_POLY   8'h07
`define VDS_SCR_LEN    43

`endif

// *** design/vds_pkg.sv ***
// Purpose: types of the container-to-slot sink
// Assumes: nothing
// Notes:   stream carriers in and out
package vds_pkg;

	// ==========================================================
	// enumerations
	typedef enum logic [2:0] {
		OK_PAY = 3'b000,
		OK_C2  = 3'b001,
		OK_H4  = 3'b010,
		OK_F2  = 3'b011,
		OK_F3  = 3'b100,
		OK_OTH = 3'b101
	} vds_okind_t;

	typedef enum logic [1:0] {
		OT_DATA = 2'b00,
		OT_SLOT = 2'b01,
		OT_M1   = 2'b10,
		OT_M2   = 2'b11
	} vds_otype_t;

	typedef enum logic [1:0] {
		LSS_CONN = 2'b00,
		LSS_UP   = 2'b01,
		LSS_HOB  = 2'b10,
		LSS_DN   = 2'b11
	} vds_lss_t;

	typedef enum logic [1:0] {
		DL_HUNT = 2'b00,
		DL_PRE  = 2'b01,
		DL_SYNC = 2'b10
	} vds_dlst_t;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic       valid;
		logic       fs;
		vds_okind_t kind;
		logic [7:0] data;
	} vds_ai_t;

	typedef struct packed {
		logic       valid;
		vds_otype_t octet_type_out;
		logic       octet_valid_out;
		logic       frame_timing_mark_out;
		logic [7:0] data;
	} vds_ci_t;

endpackage : vds_pkg

// *** design/vds_slot_sink.sv ***
// Purpose: slot sink from container octets to slot layer octets
// Assumes: octet kind tagged upstream, same clock as tsf
// Notes:   registers over AXI4-Lite
//
// Summary of operation
// [RULE1] boundaries found by offset octet or by header check correlation, selectable
// [RULE2] check mode: check octet must match the three prior header octets
// [RULE3] offset mode: offset advances by 45 modulo 53 per frame
// [RULE4] offset above range counts as unexpected, never as a boundary
// [RULE5] header check octet is xored with 0x55 before delivery
// [RULE6] payload descrambled by self-synchronous x^43+1
// [RULE7] descrambler steps only on payload octets, holds otherwise
// [RULE8] octet type marks slot start and both management octets
// [RULE9] each delivered octet carries a valid or invalid flag
// [RULE10] timing mark each frame plus link up/down output
// [RULE11] accepted label compared with 0x14, mismatch on difference
// [RULE12] top two offset-octet bits are link code, low six the offset
// [RULE13] both management octets pass through unchanged; code zeroes them on server fail with bus-head capability
// [RULE14] inactive: data all ones and no defect reports
// [RULE15] delineation loss flagged while boundaries are not tracked
// [RULE16] server fail = trail fail or mismatch or delineation loss
// [RULE17] healthy: connected/up gives up; down/hob gives down, sends up
// [RULE18] server fail with bus-head capability or forced down: link down, send down code
// [RULE19] no server fail: octets delivered marked valid
// [RULE20] server fail with bus-head capability: empty octets, link down
// [RULE21] server fail without capability: invalid octets, send hob code
// [RULE22] mismatch reported without trail fail; loss without either
// [RULE23] offset counts octets to next boundary, valid 0 to 52
// [RULE24] link codes 00 connected, 11 down, 01 up, 10 hob
// [RULE25] slot position counts payload octets only, across frames
`timescale 1ns/1ns
`include "vds_map.svh"
module vds_slot_sink
	import vds_pkg::*;
#(
	parameter int ALPHA  = 6,
	parameter int DELTA  = 7,
	parameter int ACCEPT = 5
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire vds_ai_t     ai,
	input  wire logic        trail_signal_fail_in,
	output vds_ci_t          ci,
	output logic             link_up_down_out,
	output vds_lss_t         outgoing_link_code,
	output logic             server_fail_action,
	output logic             label_mismatch_report,
	output logic             delineation_loss_report,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ==========================================================
	// reset release
	logic [1:0] rs_q;
	logic       rst_n;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rs_q <= 2'b00;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end
	assign rst_n = rs_q[1];

	// ==========================================================
	// control
	logic [3:0] ctl_q;
	logic       act;
	logic       h4m;
	logic       fdn;
	logic       hob;

	assign act = ctl_q[`VDS_CTRL_ACT];
	assign h4m = ctl_q[`VDS_CTRL_H4];
	assign fdn = ctl_q[`VDS_CTRL_FDN];
	assign hob = ctl_q[`VDS_CTRL_HOB];

	// ==========================================================
	// octet classes
	logic is_pay;
	logic is_h4;
	logic is_c2;
	logic is_mg;

	assign is_pay = ai.valid && ai.kind == OK_PAY;
	assign is_h4  = ai.valid && ai.kind == OK_H4;
	assign is_c2  = ai.valid && ai.kind == OK_C2;
	assign is_mg  = ai.valid && (ai.kind == OK_F2 || ai.kind == OK_F3);

	// ==========================================================
	// header check window
	logic [23:0] win_q;
	logic [7:0]  hcs_calc;
	logic        hcs_hit;

	vds_hcs_crc vds_hcs_crc_inst (
		.hdr (win_q),
		.crc (hcs_calc)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			win_q <= 24'h00_0000;
		end else if (is_pay) begin
			win_q <= {win_q[15:0], ai.data};
		end
	end
	assign hcs_hit = is_pay && (hcs_calc == (ai.data ^ `VDS_HCS_MASK)); // see [RULE2]

	// ==========================================================
	// offset octet
	logic [5:0] off;
	logic       off_ok;
	logic [5:0] prev_q;
	logic [6:0] sum;
	logic [5:0] exp_off;
	logic [5:0] h4_pos;

	assign off    = ai.data[5:0]; // see [RULE12]
	assign off_ok = off <= `VDS_SLOT_LAST; // see [RULE4] see [RULE23]
	assign sum    = {1'b0, prev_q} + {1'b0, `VDS_H4_STEP};
	always_comb begin
		exp_off = sum[5:0];
		if (sum >= {1'b0, `VDS_SLOT_LEN}) begin
			exp_off = 6'(sum - {1'b0, `VDS_SLOT_LEN}); // see [RULE3]
		end
	end
	// first payload octet after the offset octet sits at this position
	assign h4_pos = (off == 6'h00) ? 6'h00 : 6'(`VDS_SLOT_LEN - off); // see [RULE23]

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 6'h00;
		end else if (is_h4 && off_ok) begin
			prev_q <= off;
		end
	end

	// ==========================================================
	// delineation events
	vds_dlst_t  st_q;
	logic [3:0] cnt_q;
	logic [5:0] pos_q;
	logic       mode_q;
	logic       hunt_hit;
	logic       ev_chk;
	logic       ev_good;

	always_comb begin
		if (h4m) begin // see [RULE1]
			hunt_hit = is_h4 && off_ok;
			ev_chk   = is_h4;
			ev_good  = off_ok && off == exp_off; // see [RULE3] see [RULE4]
		end else begin
			hunt_hit = hcs_hit;
			ev_chk   = is_pay && pos_q == `VDS_HDR_END;
			ev_good  = hcs_hit; // see [RULE2]
		end
	end

	// ==========================================================
	// delineation state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= DL_HUNT;
			cnt_q  <= 4'h0;
			mode_q <= 1'b0;
		end else begin
			mode_q <= h4m;
			if (mode_q != h4m) begin
				st_q  <= DL_HUNT;
				cnt_q <= 4'h0;
			end else begin
				case (st_q)
					DL_HUNT: begin
						if (hunt_hit) begin
							st_q  <= DL_PRE;
							cnt_q <= 4'h0;
						end
					end
					DL_PRE: begin
						if (ev_chk && !ev_good) begin
							st_q <= DL_HUNT;
						end else if (ev_chk && cnt_q == 4'(ALPHA - 1)) begin
							st_q  <= DL_SYNC;
							cnt_q <= 4'h0;
						end else if (ev_chk) begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
					DL_SYNC: begin
						if (ev_chk && ev_good) begin
							cnt_q <= 4'h0;
						end else if (ev_chk && cnt_q == 4'(DELTA - 1)) begin
							st_q  <= DL_HUNT; // see [RULE15]
							cnt_q <= 4'h0;
						end else if (ev_chk) begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
					default: begin
						st_q  <= DL_HUNT;
						cnt_q <= 4'h0;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// slot position, payload octets only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pos_q <= 6'h00;
		end else if (st_q == DL_HUNT && hunt_hit) begin
			pos_q <= h4m ? h4_pos : `VDS_HDR_END + 6'h01;
		end else if (is_pay) begin
			pos_q <= (pos_q == `VDS_SLOT_LAST) ? 6'h00 : pos_q + 6'h01; // see [RULE25]
		end
	end

	// ==========================================================
	// descrambler
	logic       desc_en;
	logic [7:0] desc_out;

	assign desc_en = is_pay && pos_q >= `VDS_PAY_FIRST && st_q != DL_HUNT; // see [RULE7]

	vds_descr vds_descr_inst (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.en      (desc_en),
		.din     (ai.data),
		.dout    (desc_out)
	);

	// ==========================================================
	// label acceptance
	logic [7:0] cand_q;
	logic [2:0] ccnt_q;
	logic [7:0] acc_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cand_q <= 8'h00;
			ccnt_q <= 3'h0;
			acc_q  <= `VDS_C2_EXP;
		end else if (is_c2) begin
			if (ai.data != cand_q) begin
				cand_q <= ai.data;
				ccnt_q <= 3'h1;
			end else if (ccnt_q == 3'(ACCEPT - 1)) begin
				acc_q  <= ai.data;
				ccnt_q <= 3'(ACCEPT);
			end else if (ccnt_q < 3'(ACCEPT)) begin
				ccnt_q <= ccnt_q + 3'h1;
			end
		end
	end

	// ==========================================================
	// defects and server fail
	logic plm_q;
	logic lsd_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			plm_q                   <= 1'b0;
			lsd_q                   <= 1'b1;
			server_fail_action      <= 1'b1;
			label_mismatch_report   <= 1'b0;
			delineation_loss_report <= 1'b0;
		end else begin
			plm_q <= acc_q != `VDS_C2_EXP; // see [RULE11]
			lsd_q <= st_q != DL_SYNC; // see [RULE15]
			server_fail_action <= trail_signal_fail_in | plm_q | lsd_q; // see [RULE16]
			label_mismatch_report <= act & plm_q & ~trail_signal_fail_in; // see [RULE22] see [RULE14]
			delineation_loss_report <= act & lsd_q & ~trail_signal_fail_in & ~plm_q; // see [RULE22]
		end
	end

	// ==========================================================
	// link status table
	vds_lss_t rx_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_q <= LSS_DN;
		end else if (is_h4) begin
			rx_q <= vds_lss_t'(ai.data[7:6]); // see [RULE12] see [RULE24]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			link_up_down_out   <= 1'b0;
			outgoing_link_code <= LSS_DN;
		end else if (fdn) begin
			link_up_down_out   <= 1'b0;
			outgoing_link_code <= LSS_DN; // see [RULE18]
		end else if (server_fail_action) begin
			link_up_down_out   <= 1'b0; // see [RULE20]
			outgoing_link_code <= hob ? LSS_DN : LSS_HOB; // see [RULE18] see [RULE21]
		end else begin
			case (rx_q)
				LSS_CONN, LSS_UP: begin
					link_up_down_out   <= 1'b1; // see [RULE17]
					outgoing_link_code <= LSS_CONN;
				end
				default: begin
					link_up_down_out   <= 1'b0; // see [RULE17]
					outgoing_link_code <= LSS_UP;
				end
			endcase
		end
	end

	// ==========================================================
	// delivery toward the slot layer
	logic [7:0] dat_d;

	always_comb begin
		dat_d = ai.data; // see [RULE13]
		if (is_pay && pos_q == `VDS_HDR_END) begin
			dat_d = ai.data ^ `VDS_HCS_MASK; // see [RULE5]
		end else if (desc_en) begin
			dat_d = desc_out; // see [RULE6]
		end
		if (server_fail_action && hob) begin
			dat_d = 8'h00; // see [RULE20]
		end
		if (!act) begin
			dat_d = `VDS_ALL_ONES; // see [RULE14]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ci <= '0;
		end else begin
			ci.valid <= is_pay | is_mg;
			ci.frame_timing_mark_out <= ai.valid & ai.fs; // see [RULE10]
			ci.data <= dat_d;
			ci.octet_valid_out <= act & (~server_fail_action | hob); // see [RULE9] see [RULE19] see [RULE21]
			if (ai.kind == OK_F2) begin
				ci.octet_type_out <= OT_M1; // see [RULE8] see [RULE13]
			end else if (ai.kind == OK_F3) begin
				ci.octet_type_out <= OT_M2;
			end else if (is_pay && pos_q == 6'h00) begin
				ci.octet_type_out <= OT_SLOT; // see [RULE8]
			end else begin
				ci.octet_type_out <= OT_DATA;
			end
		end
	end

	// ==========================================================
	// register bus, write side
	logic [3:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic       aw_have_q;
	logic       w_have_q;
	logic       wr_fire;
	logic       wr_hit;

	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_hit  = awaddr_q == `VDS_REG_CTRL;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			awaddr_q      <= 4'h0;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q      <= s_axi_awaddr;
				aw_have_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_have_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_hit || awaddr_q == `VDS_REG_STAT ||
					awaddr_q == `VDS_REG_LABEL) ? 2'b00 : 2'b11;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_have_q     <= 1'b0;
				w_have_q      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q <= `VDS_CTRL_RST;
		end else if (wr_fire && wr_hit && wstrb_q[0]) begin
			ctl_q <= wdata_q[3:0];
		end
	end

	// ==========================================================
	// register bus, read side
	logic [31:0] rd_d;
	logic [1:0]  rr_d;

	always_comb begin
		rd_d = 32'h0000_0000;
		rr_d = 2'b00;
		case (s_axi_araddr)
			`VDS_REG_CTRL:  rd_d[3:0] = ctl_q;
			`VDS_REG_STAT:  rd_d = {22'h00_0000, delineation_loss_report,
				label_mismatch_report, outgoing_link_code, rx_q,
				link_up_down_out, server_fail_action, plm_q, lsd_q};
			`VDS_REG_LABEL: rd_d[7:0] = acc_q;
			default:        rr_d = 2'b11;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_d;
			s_axi_rresp   <= rr_d;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_ssf_on_tsf: assert property (trail_signal_fail_in |=> server_fail_action) // see [RULE16]
		else $error("trail fail did not raise server fail");
	a_plm_report_gate: assert property (label_mismatch_report |-> // see [RULE22]
		$past(plm_q && !trail_signal_fail_in && act))
		else $error("mismatch reported without cause");
	a_lsd_report_gate: assert property (delineation_loss_report |-> // see [RULE22]
		$past(lsd_q && !plm_q && !trail_signal_fail_in && act))
		else $error("delineation loss reported without cause");
	a_force_down: assert property (fdn |=> // see [RULE18]
		!link_up_down_out && outgoing_link_code == LSS_DN)
		else $error("forced down not obeyed");
	a_hob_incap_code: assert property ((!fdn && server_fail_action && !hob) |=> // see [RULE21]
		outgoing_link_code == LSS_HOB && !link_up_down_out)
		else $error("hob incapable code missing");
	a_link_up_table: assert property ((!fdn && !server_fail_action && rx_q == LSS_UP) // see [RULE17]
		|=> link_up_down_out && outgoing_link_code == LSS_CONN)
		else $error("link up table wrong");
	a_inactive_ones: assert property ((is_mg && !act) |=> ci.data == `VDS_ALL_ONES) // see [RULE14]
		else $error("inactive output not all ones");
	a_mgmt_pass: assert property ((ai.valid && ai.kind == OK_F2 && act && !server_fail_action) // see [RULE13]
		|=> ci.valid && ci.octet_type_out == OT_M1 && ci.data == $past(ai.data))
		else $error("management octet altered");
	a_slot_type: assert property ((is_pay && pos_q == 6'h00) |=> // see [RULE8]
		ci.octet_type_out == OT_SLOT)
		else $error("slot start not marked");
	a_tmark_frame: assert property ((ai.valid && ai.fs) |=> ci.frame_timing_mark_out) // see [RULE10]
		else $error("timing mark missing");
	a_empty_hob: assert property ((is_pay && act && server_fail_action && hob) |=> // see [RULE20]
		ci.data == 8'h00 && ci.octet_valid_out)
		else $error("empty slot not delivered");
	a_bad_offset: assert property ((st_q == DL_HUNT && h4m && mode_q && is_h4 && !off_ok) // see [RULE4]
		|=> st_q == DL_HUNT)
		else $error("out of range offset taken as boundary");

	c_reach_sync: cover property (st_q == DL_PRE ##1 st_q == DL_SYNC);
	c_lose_sync: cover property (st_q == DL_SYNC ##1 st_q == DL_HUNT);
	c_plm_seen: cover property (label_mismatch_report);
	c_write_done: cover property (s_axi_bvalid && s_axi_bready);

endmodule : vds_slot_sink

// *** tb/vds_dqdb_node.sv ***
// Purpose: slot layer node model, counts slots handed over
// Assumes: ci registered, strobes one cycle wide
// Notes:   the node cannot push back, so no ready
`timescale 1ns/1ns
module vds_dqdb_node
	import vds_pkg::*;
(
	input  wire logic    clk_sys,
	input  wire vds_ci_t ci,
	output int           slot_cnt
);
	// ==========================================================
	// slot starts seen valid
	int cnt = 0;

	assign slot_cnt = cnt;
	always @(posedge clk_sys) begin
		if (ci.valid && ci.octet_type_out == OT_SLOT && ci.octet_valid_out) begin
			cnt <= cnt + 1;
		end
	end
endmodule : vds_dqdb_node

// *** tb/vds_slot_sink_bench.sv ***
// Purpose: self-checking bench of the slot sink
// Assumes: one zero-header slot per frame, check octet 0x55
// Notes:   one octet every two cycles, outputs read after the edge
`timescale 1ns/1ns
`include "vds_map.svh"
module vds_slot_sink_bench;
	import vds_pkg::*;
	// ==========================================================
	// signals
	logic        clk_sys = 1'h0;
	logic        resetn = 1'h0;
	logic        trail_signal_fail_in = 1'h0;
	vds_ai_t     ai = '0;
	vds_ci_t     ci, f2o, f3o, hco, pdo;
	logic [7:0]  pv = 8'h00;
	logic        link_up_down_out, server_fail_action, mk;
	logic        label_mismatch_report, delineation_loss_report;
	vds_lss_t    outgoing_link_code;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int          error_cnt = 0, total_checks = 0, cyc = 0, sc, i, slot_cnt;

	vds_slot_sink vds_slot_sink_inst (.clk_sys, .resetn, .ai, .trail_signal_fail_in, .ci,
		.link_up_down_out, .outgoing_link_code, .server_fail_action, .label_mismatch_report,
		.delineation_loss_report, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	vds_dqdb_node vds_dqdb_node_inst (.clk_sys, .ci, .slot_cnt);

	// ==========================================================
	// clock, timeout
	initial forever #20 clk_sys = ~clk_sys;
	// run takes about 4000 cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// ==========================================================
	// shared tasks
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// ready is registered, so its level at negedge is what the next edge samples
	task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do @(negedge clk_sys); while (!(s_axi_awready && s_axi_wready));
		@(posedge clk_sys);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		do @(negedge clk_sys); while (!s_axi_bvalid);
		chk(s_axi_bresp, r);
		@(posedge clk_sys);
		s_axi_bready <= 1'h0;
	endtask : axw

	task axr(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(negedge clk_sys); while (!s_axi_arready);
		@(posedge clk_sys);
		s_axi_arvalid <= 1'h0;
		do @(negedge clk_sys); while (!s_axi_rvalid);
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, r);
		@(posedge clk_sys);
		s_axi_rready <= 1'h0;
	endtask : axr

	task oct(input logic f, input vds_okind_t k, input logic [7:0] d);
		@(posedge clk_sys);
		ai <= '{valid: 1'h1, fs: f, kind: k, data: d};
		@(posedge clk_sys);
		ai.valid <= 1'h0;
		#1;
	endtask : oct

	task frm(input logic [7:0] c2, input logic [7:0] h4);
		oct(1'h1, OK_C2, c2);
		mk = ci.frame_timing_mark_out;
		oct(1'h0, OK_H4, h4);
		oct(1'h0, OK_F2, 8'ha5);
		f2o = ci;
		oct(1'h0, OK_F3, 8'h3c);
		f3o = ci;
		for (i = 0; i < 53; i++) begin
			oct(1'h0, OK_PAY, (i == 3) ? 8'h55 : (i == 10) ? pv : 8'h00);
			if (i == 3) hco = ci;
			if (i == 15) pdo = ci;
		end
	endtask : frm

	// ==========================================================
	// scenarios
	task s_reset;
		axw(4'hc, 32'h0000_000f, 2'h3);
		axr(`VDS_REG_CTRL, 32'h0000_0000, 2'h0);
		axr(`VDS_REG_LABEL, 32'h0000_0014, 2'h0);
		axr(4'hc, 32'h0000_0000, 2'h3);
		chk(link_up_down_out, 1'h0);
	endtask : s_reset

	task s_fail;
		frm(8'h14, 8'h00);
		chk(f2o.data, 8'hff);
		chk(label_mismatch_report | delineation_loss_report, 1'h0);
		axw(`VDS_REG_CTRL, 32'h0000_0009, 2'h0);
		frm(8'h14, 8'h00);
		chk({f2o.data, f2o.octet_valid_out}, 9'h001);
		chk(outgoing_link_code, LSS_DN);
		axw(`VDS_REG_CTRL, 32'h0000_0001, 2'h0);
		frm(8'h14, 8'h00);
		chk(f2o.octet_valid_out, 1'h0);
		chk(outgoing_link_code, LSS_HOB);
		chk(server_fail_action & delineation_loss_report, 1'h1);
	endtask : s_fail

	task s_sync;
		axw(`VDS_REG_CTRL, 32'h0000_0009, 2'h0);
		repeat (9) frm(8'h14, 8'h00);
		sc = slot_cnt;
		pv = 8'h80;
		frm(8'h14, 8'h00);
		pv = 8'h00;
		chk(slot_cnt - sc, 1);
		// a lone bit returns 43 bits later: octet +5, fourth bit
		chk(pdo.data, 8'h10);
		chk(server_fail_action | delineation_loss_report, 1'h0);
		chk({f2o.data, f2o.octet_type_out, f2o.octet_valid_out}, {8'ha5, OT_M1, 1'h1});
		chk({f3o.data, f3o.octet_type_out}, {8'h3c, OT_M2});
		chk(hco.data, 8'h00);
		chk(mk, 1'h1);
		for (int c = 0; c < 4; c++) begin
			frm(8'h14, {c[1:0], 6'h00});
			chk(link_up_down_out, c < 2);
			chk(outgoing_link_code, (c < 2) ? LSS_CONN : LSS_UP);
		end
		axw(`VDS_REG_CTRL, 32'h0000_000d, 2'h0);
		frm(8'h14, 8'h00);
		chk({link_up_down_out, outgoing_link_code}, {1'h0, LSS_DN});
		axw(`VDS_REG_CTRL, 32'h0000_0009, 2'h0);
	endtask : s_sync

	task s_label;
		repeat (6) frm(8'h00, 8'h00);
		chk(label_mismatch_report & server_fail_action, 1'h1);
		chk(delineation_loss_report, 1'h0);
		axr(`VDS_REG_LABEL, 32'h0000_0000, 2'h0);
		@(posedge clk_sys);
		trail_signal_fail_in <= 1'h1;
		frm(8'h00, 8'h00);
		chk({label_mismatch_report, server_fail_action}, 2'h1);
	endtask : s_label

	// offset mode: a bad offset first, then offsets stepping by 45 mod 53
	task s_h4;
		@(posedge clk_sys);
		trail_signal_fail_in <= 1'h0;
		axw(`VDS_REG_CTRL, 32'h0000_000b, 2'h0);
		frm(8'h14, 8'h3f);
		for (int k = 0; k < 6; k++) begin
			frm(8'h14, 8'(45 * k % 53));
		end
		chk(delineation_loss_report, 1'h1);
		frm(8'h14, 8'h05);
		chk({delineation_loss_report, server_fail_action}, 2'h0);
	endtask : s_h4

	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'h1;
		repeat (4) @(posedge clk_sys);
		s_reset();
		s_fail();
		s_sync();
		s_label();
		s_h4();
		print_verdict();
	end
endmodule : vds_slot_sink_bench
